// ==== rtl/sbst_pkg.sv ====
// constants, types and decode functions of the sram boundary-scan test port
package sbst_pkg;

  localparam int IR_WIDTH  = 3;
  localparam int ID_WIDTH  = 32;
  localparam int BSR_WIDTH = 69;

  // identification register field positions
  localparam int ID_REV_MSB   = 31;
  localparam int ID_REV_LSB   = 29;
  localparam int ID_DEV_MSB   = 28;
  localparam int ID_DEV_LSB   = 12;
  localparam int ID_VEN_MSB   = 11;
  localparam int ID_VEN_LSB   = 1;
  localparam int ID_PRESENCE  = 0;
  localparam logic ID_PRESENCE_VALUE = 1'h1;

  // instruction codes
  localparam logic [IR_WIDTH-1:0] INSTR_EXTEST  = 3'h0;
  localparam logic [IR_WIDTH-1:0] INSTR_IDCODE  = 3'h1;
  localparam logic [IR_WIDTH-1:0] INSTR_SAMPLEZ = 3'h2;
  localparam logic [IR_WIDTH-1:0] INSTR_PRELOAD = 3'h4;
  localparam logic [IR_WIDTH-1:0] INSTR_BYPASS  = 3'h7;

  // reset and capture values
  localparam logic [IR_WIDTH-1:0] IR_RESET_VALUE   = INSTR_IDCODE;
  localparam logic [IR_WIDTH-1:0] IR_CAPTURE_VALUE = 3'h1;
  localparam logic                BYPASS_CAPTURE   = 1'h0;

  // output-enable cell of the boundary chain, preset high
  localparam int OE_CELL = 50;
  localparam logic [BSR_WIDTH-1:0] BSR_PRESET = 69'h1 << OE_CELL;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE,
    TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR,
    TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } sbst_tap_state_type;

  typedef enum logic [1:0] {
    PATH_BYPASS, PATH_ID, PATH_BOUNDARY
  } sbst_path_type;

  function automatic sbst_path_type sbst_decode_path(logic [IR_WIDTH-1:0] instr);
    sbst_path_type path;
    unique case (instr)
      INSTR_EXTEST, INSTR_SAMPLEZ, INSTR_PRELOAD: path = PATH_BOUNDARY;
      INSTR_IDCODE: path = PATH_ID;
      default: path = PATH_BYPASS;
    endcase
    return path;
  endfunction

  function automatic logic sbst_forces_highz(logic [IR_WIDTH-1:0] instr);
    return (instr == INSTR_EXTEST) || (instr == INSTR_SAMPLEZ);
  endfunction

endpackage

// ==== rtl/sbst_sync.sv ====
// two flip-flop synchroniser for a level or a quasi-static word
`timescale 1ns/1ps
module sbst_sync
  import sbst_pkg::*;
#(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sbst_sync_state_type;

  sbst_sync_state_type s_reg;
  sbst_sync_state_type s_next;

  // stage1 is read only by stage2
  always_comb
  begin
    s_next.stage1 = d;
    s_next.stage2 = s_reg.stage1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_reg <= {RESET_VALUE, RESET_VALUE};
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign q = s_reg.stage2;

endmodule

// ==== rtl/sbst_fsm.sv ====
// sixteen-state test-access controller stepping on the test clock
`timescale 1ns/1ps
module sbst_fsm
  import sbst_pkg::*;
(
  input  wire logic         tck,
  input  wire logic         tapRst,
  input  wire logic         enable,
  input  wire logic         tms,
  output sbst_tap_state_type state
);

  typedef struct packed {
    sbst_tap_state_type state;
  } sbst_fsm_state_type;

  sbst_fsm_state_type f_reg;
  sbst_fsm_state_type f_next;

  // five edges with tms high reach reset from any state
  always_comb
  begin
    f_next = f_reg;
    if (enable)
    begin
      unique case (f_reg.state) // see R16
        TAP_RESET:    f_next.state = tms ? TAP_RESET : TAP_IDLE;
        TAP_IDLE:     f_next.state = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR:   f_next.state = tms ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR:   f_next.state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_SHIFT_DR: f_next.state = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
        TAP_EXIT1_DR: f_next.state = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: f_next.state = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
        TAP_EXIT2_DR: f_next.state = tms ? TAP_UPD_DR : TAP_SHIFT_DR;
        TAP_UPD_DR:   f_next.state = tms ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR:   f_next.state = tms ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR:   f_next.state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_SHIFT_IR: f_next.state = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
        TAP_EXIT1_IR: f_next.state = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: f_next.state = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
        TAP_EXIT2_IR: f_next.state = tms ? TAP_UPD_IR : TAP_SHIFT_IR;
        TAP_UPD_IR:   f_next.state = tms ? TAP_SEL_DR : TAP_IDLE;
      endcase
    end
  end

  always_ff @(posedge tck)
  begin
    if (tapRst)
    begin
      f_reg.state <= TAP_RESET;
    end
    else
    begin
      f_reg <= f_next;
    end
  end

  assign state = f_reg.state;

endmodule

// ==== rtl/sbst_tap.sv ====
// boundary-scan test access port of the sram, test-clock side and memory-clock side
//
// Operation
// R1 - Provide a 3-bit instruction, 1-bit bypass, 32-bit identification and 69-bit boundary register.
// R2 - The identification word holds revision in 31:29, device in 28:12 and vendor in 11:1.
// R3 - Identification bit zero always reads as one.
// R4 - Code 000 captures the ring, selects the boundary chain and forces memory outputs high-Z.
// R5 - Code 001 loads the identification value and selects it, memory unaffected.
// R6 - Code 010 captures the ring, selects the boundary chain and forces memory drivers high-Z.
// R7 - Code 100 captures the ring and selects the boundary chain without disturbing memory.
// R8 - Code 111 selects the one-bit bypass register without affecting memory.
// R9 - The controller never loads the reserved codes 011, 101 or 110; here they are loaded and decode as bypass.
// R10 - Mode select and serial data in are sampled on the rising test-clock edge.
// R11 - Serial data out changes after the falling test-clock edge.
// R12 - Mode select high for five rising edges resets the port without disturbing memory.
// R13 - At power-up and in test-logic-reset the instruction becomes the identification code.
// R14 - In instruction capture the low two bits of the instruction shifter load 01.
// R15 - The output-enable cell is preset high and in external test gates the ring drivers.
// R16 - A sixteen-state controller steps on rising test-clock edges by the mode-select value.
`timescale 1ns/1ps
module sbst_tap
  import sbst_pkg::*;
#(
  parameter logic [ID_REV_MSB-ID_REV_LSB:0] ID_REVISION = 3'h5,     // arbitrary value
  parameter logic [ID_DEV_MSB-ID_DEV_LSB:0] ID_DEVICE   = 17'h0a5a5, // arbitrary value
  parameter logic [ID_VEN_MSB-ID_VEN_LSB:0] ID_VENDOR   = 11'h2c3   // arbitrary value
)
(
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire logic                 clkEnable,
  input  wire logic                 tck,
  input  wire logic                 tms,
  input  wire logic                 tdi,
  output logic                      tdo,
  output logic                      tdoOe,
  input  wire logic [BSR_WIDTH-1:0] ringIn,
  output logic      [BSR_WIDTH-1:0] ringOut,
  output logic                      ringDrive,
  output logic                      ringOutEnable,
  output logic                      memOutHighZ,
  output logic      [IR_WIDTH-1:0]  activeInstruction
);

  localparam logic [ID_WIDTH-1:0] ID_CODE = {ID_REVISION, ID_DEVICE, ID_VENDOR, ID_PRESENCE_VALUE}; // see R2 see R3

  localparam int CROSS_WIDTH = BSR_WIDTH + IR_WIDTH + 2;
  localparam logic [CROSS_WIDTH-1:0] CROSS_RESET = {BSR_PRESET, IR_RESET_VALUE, 2'h0};

  // test-clock side state
  typedef struct packed { // see R1
    logic [IR_WIDTH-1:0]  instr;
    logic [IR_WIDTH-1:0]  instrShift;
    logic                 bypass;
    logic [ID_WIDTH-1:0]  idShift;
    logic [BSR_WIDTH-1:0] bsrShift;
    logic [BSR_WIDTH-1:0] bsrUpdate;
  } sbst_tck_state_type;

  // falling-edge output stage
  typedef struct packed {
    logic serial;
    logic enable;
  } sbst_out_state_type;

  // memory-clock side state
  typedef struct packed {
    logic [BSR_WIDTH-1:0] ringOut;
    logic                 ringDrive;
    logic                 ringOutEnable;
    logic                 memOutHighZ;
    logic [IR_WIDTH-1:0]  instr;
    logic [CROSS_WIDTH-1:0] lastWord;
  } sbst_clk_state_type;

  localparam sbst_tck_state_type TCK_RESET = '{
    instr:      IR_RESET_VALUE,
    instrShift: IR_RESET_VALUE,
    bypass:     BYPASS_CAPTURE,
    idShift:    ID_CODE,
    bsrShift:   BSR_PRESET,
    bsrUpdate:  BSR_PRESET
  };

  sbst_tck_state_type t_reg;
  sbst_tck_state_type t_next;
  sbst_out_state_type o_reg;
  sbst_out_state_type o_next;
  sbst_clk_state_type c_reg;
  sbst_clk_state_type c_next;

  logic                   tapRst;
  logic                   tckEnable;
  logic [BSR_WIDTH-1:0]   ringSampled;
  sbst_tap_state_type     tapState;
  sbst_path_type          path;
  logic                   serialBit;
  logic                   shifting;
  logic                   extestActive;
  logic [CROSS_WIDTH-1:0] crossToClk;
  logic [CROSS_WIDTH-1:0] crossedWord;

  // system reset and enable enter the test-clock domain through two flops;
  // the port is not reset until reset has been seen on tck
  sbst_sync #(
    .WIDTH       (2),
    .RESET_VALUE (2'h0)
  ) u_ctrl_sync (
    .clk (tck),
    .rst (1'b0),
    .d   ({reset, clkEnable}),
    .q   ({tapRst, tckEnable})
  );

  // ring values change on the memory clock; capture may still see a transition
  sbst_sync #(
    .WIDTH       (BSR_WIDTH),
    .RESET_VALUE ('0)
  ) u_ring_sync (
    .clk (tck),
    .rst (tapRst),
    .d   (ringIn),
    .q   (ringSampled)
  );

  sbst_fsm u_fsm (
    .tck    (tck),
    .tapRst (tapRst),
    .enable (tckEnable),
    .tms    (tms),
    .state  (tapState)
  );

  assign path = sbst_decode_path(t_reg.instr); // see R4 see R5 see R6 see R7 see R8

  // reserved codes fall back to bypass so the chain never breaks
  always_comb
  begin
    t_next = t_reg;
    if (tckEnable)
    begin
      unique case (tapState)
        TAP_RESET:
        begin
          t_next.instr     = IR_RESET_VALUE; // see R13 see R12
          t_next.bsrUpdate = BSR_PRESET;     // see R15
        end
        TAP_CAP_IR:
        begin
          t_next.instrShift = IR_CAPTURE_VALUE; // see R14
        end
        TAP_SHIFT_IR:
        begin
          t_next.instrShift = {tdi, t_reg.instrShift[IR_WIDTH-1:1]}; // see R10
        end
        TAP_UPD_IR:
        begin
          t_next.instr = t_reg.instrShift;
        end
        TAP_CAP_DR:
        begin
          unique case (path)
            PATH_BOUNDARY: t_next.bsrShift = ringSampled; // see R4 see R6 see R7
            PATH_ID:       t_next.idShift  = ID_CODE;     // see R5
            PATH_BYPASS:   t_next.bypass   = BYPASS_CAPTURE; // see R8
          endcase
        end
        TAP_SHIFT_DR:
        begin
          // msb faces serial in, lsb faces serial out
          unique case (path)
            PATH_BOUNDARY: t_next.bsrShift = {tdi, t_reg.bsrShift[BSR_WIDTH-1:1]}; // see R10
            PATH_ID:       t_next.idShift  = {tdi, t_reg.idShift[ID_WIDTH-1:1]};
            PATH_BYPASS:   t_next.bypass   = tdi;
          endcase
        end
        TAP_UPD_DR:
        begin
          if (path == PATH_BOUNDARY)
          begin
            t_next.bsrUpdate = t_reg.bsrShift; // see R7
          end
        end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge tck)
  begin
    if (tapRst)
    begin
      t_reg <= TCK_RESET; // see R13 see R15
    end
    else
    begin
      t_reg <= t_next;
    end
  end

  assign shifting = (tapState == TAP_SHIFT_IR) || (tapState == TAP_SHIFT_DR);

  always_comb
  begin
    serialBit = t_reg.bypass;
    if (tapState == TAP_SHIFT_IR)
    begin
      serialBit = t_reg.instrShift[0];
    end
    else if (path == PATH_BOUNDARY)
    begin
      serialBit = t_reg.bsrShift[0];
    end
    else if (path == PATH_ID)
    begin
      serialBit = t_reg.idShift[0];
    end
  end

  always_comb
  begin
    o_next = o_reg;
    if (tckEnable)
    begin
      o_next.serial = serialBit;
      o_next.enable = shifting;
    end
  end

  // output moves on the falling edge, a half period ahead of the far sampling edge
  always_ff @(negedge tck)
  begin
    if (tapRst)
    begin
      o_reg <= '0;
    end
    else
    begin
      o_reg <= o_next; // see R11
    end
  end

  assign tdo   = o_reg.serial;
  assign tdoOe = o_reg.enable;

  assign extestActive = (t_reg.instr == INSTR_EXTEST);

  // the update word is quasi-static: it only changes in update states and in test-logic-reset
  assign crossToClk = {t_reg.bsrUpdate, t_reg.instr, extestActive, sbst_forces_highz(t_reg.instr)};

  sbst_sync #(
    .WIDTH       (CROSS_WIDTH),
    .RESET_VALUE (CROSS_RESET)
  ) u_clk_sync (
    .clk (clk),
    .rst (reset),
    .d   (crossToClk),
    .q   (crossedWord)
  );

  always_comb
  begin
    c_next = c_reg;
    if (clkEnable)
    begin
      c_next.lastWord = crossedWord;
      // a sample that disagrees with the one before may be torn; one clk of latency buys a coherent word
      if (crossedWord == c_reg.lastWord)
      begin
        c_next.ringOut       = crossedWord[CROSS_WIDTH-1 -: BSR_WIDTH];
        c_next.instr         = crossedWord[IR_WIDTH+1 -: IR_WIDTH];
        c_next.ringDrive     = crossedWord[1];
        c_next.memOutHighZ   = crossedWord[0]; // see R4 see R6
        c_next.ringOutEnable = crossedWord[1] && crossedWord[2+IR_WIDTH+OE_CELL]; // see R15
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      c_reg.ringOut       <= BSR_PRESET;
      c_reg.instr         <= IR_RESET_VALUE;
      c_reg.ringDrive     <= 1'h0;
      c_reg.ringOutEnable <= 1'h0;
      c_reg.memOutHighZ   <= 1'h0;
      c_reg.lastWord      <= CROSS_RESET;
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  assign ringOut           = c_reg.ringOut;
  assign ringDrive         = c_reg.ringDrive;
  assign ringOutEnable     = c_reg.ringOutEnable;
  assign memOutHighZ       = c_reg.memOutHighZ;
  assign activeInstruction = c_reg.instr;

endmodule

// ==== bench/sbst_tap_props.sv ====
// assertion checker for the sram boundary-scan test port
`timescale 1ns/1ps
module sbst_tap_props
  import sbst_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 reset,
  input wire logic                 clkEnable,
  input wire logic                 tck,
  input wire logic                 tms,
  input wire logic                 tdi,
  input wire logic                 tdo,
  input wire logic                 tdoOe,
  input wire logic [BSR_WIDTH-1:0] ringIn,
  input wire logic [BSR_WIDTH-1:0] ringOut,
  input wire logic                 ringDrive,
  input wire logic                 ringOutEnable,
  input wire logic                 memOutHighZ,
  input wire logic [IR_WIDTH-1:0]  activeInstruction
);
  // tms walks from any state into reset, then idle
  sequence tapResetSeq;
    tms [*5] ##1 !tms;
  endsequence
  sequence toShiftDr;
    tms ##1 !tms ##1 !tms;
  endsequence
  sequence toShiftIr;
    tms ##1 tms ##1 !tms ##1 !tms;
  endsequence
  a_highz_decode: assert property (@(posedge clk) disable iff (reset)
    memOutHighZ == (activeInstruction == 3'h0 || activeInstruction == 3'h2)) else $error("high-z decode");
  a_drive_extest: assert property (@(posedge clk) disable iff (reset)
    ringDrive == (activeInstruction == 3'h0)) else $error("ring drive decode");
  a_oe_gating: assert property (@(posedge clk) disable iff (reset)
    ringOutEnable == (ringDrive && ringOut[OE_CELL])) else $error("enable cell gating");
  a_reset_values: assert property (@(posedge clk)
    reset |=> activeInstruction == 3'h1 && ringOut == BSR_PRESET && !memOutHighZ && !ringDrive)
    else $error("reset values");
  a_shift_hold: assert property (@(posedge tck) disable iff (reset)
    tdoOe && !tms |=> tdoOe) else $error("shift left early");
  a_shift_exit: assert property (@(posedge tck) disable iff (reset)
    tdoOe && tms |=> !tdoOe) else $error("shift not left");
  a_id_after_reset: assert property (@(posedge tck) disable iff (reset)
    tapResetSeq ##1 toShiftDr |=> tdoOe && tdo) else $error("no id bit after reset");
  a_ir_capture: assert property (@(posedge tck) disable iff (reset)
    tapResetSeq ##1 toShiftIr |=> tdoOe && tdo) else $error("ir capture bit");
endmodule

bind sbst_tap sbst_tap_props chk (.clk(clk), .reset(reset), .clkEnable(clkEnable), .tck(tck), .tms(tms),
  .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .ringIn(ringIn), .ringOut(ringOut), .ringDrive(ringDrive),
  .ringOutEnable(ringOutEnable), .memOutHighZ(memOutHighZ), .activeInstruction(activeInstruction));

// ==== bench/sbst_scan_ctl.sv ====
// behavioural board-level scan controller; test clock stands still between frames
`timescale 1ns/1ps
module sbst_scan_ctl
(
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // drive after the fall, sample tdo at the rise where it is settled
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #15 tck = 1'b1;
    o = tdo;
    #15 tck = 1'b0;
  endtask
  task automatic tap_reset();
    logic o;
    repeat (5) step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
  // from idle; lsb first, last bit leaves shift; ends in idle with tdi released
  task automatic scan(input logic ir, input int n, input logic [71:0] din, output logic [71:0] dout);
    logic o;
    dout = '0;
    step(1'b1, ~tdi, o);
    if (ir)
      step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
    step(1'b0, ~tdi, o);
    for (int k = 0; k < n; k++)
    begin
      step(k == n - 1, din[k], o);
      dout[k] = o;
    end
    step(1'b1, ~tdi, o);
    step(1'b0, ~tdi, o);
  endtask
endmodule

// ==== bench/test_sram_boundary_scan_tap.sv ====
// self-checking bench of the sram boundary-scan test port
`timescale 1ns/1ps
module test_sram_boundary_scan_tap
  import sbst_pkg::*;
;
  localparam logic [2:0]  REV    = 3'h2;     // arbitrary value
  localparam logic [16:0] DEV    = 17'h1b3c4; // arbitrary value
  localparam logic [10:0] VEN    = 11'h155;   // arbitrary value
  localparam logic [31:0] ID_EXP = {REV, DEV, VEN, 1'h1};
  logic                 clk, reset, clkEnable, tck, tms, tdi, tdo, tdoOe;
  logic [BSR_WIDTH-1:0] ringIn, ringOut;
  logic                 ringDrive, ringOutEnable, memOutHighZ;
  logic [IR_WIDTH-1:0]  activeInstruction;
  logic [71:0]          expQ[$], gotVal, din, dout, cap;
  string                nameQ[$];
  int                   err_total = 0, samples_checked = 0, cycles = 0, len;
  event                 gotEv;

  sbst_tap #(.ID_REVISION(REV), .ID_DEVICE(DEV), .ID_VENDOR(VEN)) uut (.clk(clk), .reset(reset),
    .clkEnable(clkEnable), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .ringIn(ringIn),
    .ringOut(ringOut), .ringDrive(ringDrive), .ringOutEnable(ringOutEnable), .memOutHighZ(memOutHighZ),
    .activeInstruction(activeInstruction));
  // an undriven tdo shows the inverse of its last bit, so a missing enable is seen
  sbst_scan_ctl ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoOe ? tdo : ~tdo));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic wrap_up();
    if (err_total == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // generous ceiling: the walk needs some 460 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      wrap_up();
    end
  end
  task automatic note(input string n, input logic [71:0] e);
    nameQ.push_back(n);
    expQ.push_back(e);
  endtask
  task automatic see(input logic [71:0] v);
    gotVal = v;
    ->gotEv;
    #1;
  endtask
  always @(gotEv)
  begin
    samples_checked++;
    if (gotVal !== expQ[0])
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nameQ[0], expQ[0], gotVal);
    end
    void'(expQ.pop_front());
    void'(nameQ.pop_front());
  end
  // crossing to the memory side takes 4 clk edges, 5 after a torn sample; 6 covers both
  task automatic settle();
    repeat (6) @(posedge clk);
    #2;
  endtask
  function automatic logic [71:0] chain(logic [71:0] c, int l, logic [71:0] d);
    return (d << l) | (c & ((72'h1 << l) - 72'h1));
  endfunction

  initial
  begin
    reset = 1'b1;
    clkEnable = 1'b1;
    void'($urandom(34));
    ringIn = {5'($urandom), $urandom, $urandom};
    fork
      repeat (5) @(posedge clk);
      ctl.tap_reset();
    join
    #2 reset = 1'b0;
    note("instruction", 72'h1); see(72'(activeInstruction));
    note("ring out", 72'(BSR_PRESET)); see(72'(ringOut));
    ctl.tap_reset();
    din = {8'($urandom), $urandom, $urandom};
    ctl.scan(1'b0, 72, din, dout);
    note("id chain", chain(72'(ID_EXP), 32, din)); see(dout);
    // reserved codes are skipped; the controller never loads them, though the port would decode them as bypass
    for (int c = 0; c < 8; c++)
    begin
      if (c == 3 || c == 5 || c == 6) continue;
      @(posedge clk) #2 ringIn = {5'($urandom), $urandom, $urandom};
      ctl.scan(1'b1, 3, 72'(c), dout);
      note("ir capture", 72'h1); see({69'h0, dout[2:0]});
      settle();
      note("instruction", 72'(c)); see(72'(activeInstruction));
      note("high-z", 72'(c == 0 || c == 2)); see(72'(memOutHighZ));
      note("drive", 72'(c == 0)); see(72'(ringDrive));
      din = {8'($urandom), $urandom, $urandom};
      cap = '0;
      len = 1;
      if (c == 1)
      begin
        cap = 72'(ID_EXP);
        len = 32;
      end
      else if (c == 0 || c == 2 || c == 4)
      begin
        cap = 72'(ringIn);
        len = 69;
      end
      ctl.scan(1'b0, 72, din, dout);
      note("data chain", chain(cap, len, din)); see(dout);
      if (len == 69)
      begin
        settle();
        note("ring out", 72'(din[71:3])); see(72'(ringOut));
        note("oe cell", 72'(c == 0 && din[3+OE_CELL])); see(72'(ringOutEnable));
      end
    end
    ctl.tap_reset();
    settle();
    note("instruction", 72'h1); see(72'(activeInstruction));
    note("ring out", 72'(BSR_PRESET)); see(72'(ringOut));
    note("oe cell", 72'h0); see(72'(ringOutEnable));
    ctl.scan(1'b1, 3, 72'h7, dout);
    note("ir capture", 72'h1); see({69'h0, dout[2:0]});
    settle();
    wrap_up();
  end
endmodule
